// >>> core/ppc_pkg.sv
package ppc_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_PA_IN = 6'h00;
  localparam logic [5:0] IDX_PA_DIR = 6'h01;
  localparam logic [5:0] IDX_PA_OUT = 6'h02;
  localparam logic [5:0] IDX_PB_IN = 6'h03;
  localparam logic [5:0] IDX_PB_DIR = 6'h04;
  localparam logic [5:0] IDX_PB_OUT = 6'h05;
  localparam logic [5:0] IDX_PORT_CONTROL = 6'h12;
  localparam logic [5:0] IDX_MCU_CONTROL = 6'h35;
  // reset values
  localparam logic [7:0] PORT_CONTROL_RST = 8'h00;
  localparam logic [7:0] MCU_CONTROL_RST = 8'h00;
  localparam logic [7:0] PORT_DIR_RST = 8'h00;
  localparam logic [7:0] PORT_OUT_RST = 8'h00;
  // writable bits, the rest read zero
  localparam logic [7:0] PORT_CONTROL_MASK = 8'h33;
  localparam logic [7:0] MCU_CONTROL_MASK = 8'h70;
  // field positions
  localparam int GLOBAL_PULLUP_OFF = 4;
  localparam int BROWNOUT_SLEEP_UNLOCK = 5;
  localparam int BROWNOUT_SLEEP_OFF = 6;
  localparam int PORT_A_PULLUP_OFF = 0;
  localparam int PORT_B_PULLUP_OFF = 1;
  localparam int PORT_A_MAKE_DELAY = 4;
  localparam int PORT_B_MAKE_DELAY = 5;
  // pin positions inside a port
  localparam int PIN_RX = 0;
  localparam int PIN_TX = 1;
  localparam int PIN_MISO = 2;
  localparam int PIN_MOSI = 4;
  localparam int PIN_CLOCK_IN = 4;
  localparam int PIN_CLOCK_OUT = 5;
  localparam int PIN_T1_CMP = 6;
  localparam int PIN_RESET = 7;
  // fuse positions in the synchronised fuse vector
  localparam int FUSE_RST_DIS = 0;
  localparam int FUSE_DEBUG = 1;
  localparam int FUSE_LOCK = 2;
  localparam int FUSE_CLK_OUT = 3;
  localparam int FUSE_CLKPIN = 4;
  localparam int FUSE_W = 5;
endpackage

// >>> core/ppc_top.sv
`timescale 1ns/1ps
// Functional notes
// R1: global pull-up off bit disables every pull-up in both ports except the debug pull-up on the reset pin.
// R2: port pull-up off bit ORed with global bit disables that port.
// R3: make-delay bit inserts one tri-state cycle when a pin becomes output.
// R4: SPI slave forces MOSI to input; master leaves its direction bit.
// R5: pins forced to input by SPI keep output bit pull-up control.
// R6: SPI master forces MISO to input; slave leaves its direction bit.
// R7: three-wire data replaces output bit; driven only when direction set.
// R8: UART transmitter or LIN enable forces transmit pin to output.
// R9: UART receiver or LIN enable forces receive pin to input.
// R10: forced receive pin gets pull-up from its output bit.
// R11: reset pin is I/O only when disable fuse set; else reads 0.
// R12: debug fuse with unlocked part makes reset pin open-drain with pull-up.
// R13: software sets direction bit before timer compare output reaches pin.
// R14: clock-output fuse drives divided clock on its pin, also in reset.
// R15: clock input pin stops acting as I/O; its bits read 0.
// R16: reserved control bits read zero and ignore writes.
module ppc_top (
  input wire logic mclk_i, // 250 MHz clock
  input wire logic reset_i, // synchronous reset, active high
  input wire logic ce_i, // clock enable, freezes state when low
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [7:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte lanes
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  input wire logic [7:0] pa_pin_i, // port a pin levels
  output logic [7:0] pa_out_o, // port a drive value
  output logic [7:0] pa_oe_o, // port a output enable
  output logic [7:0] pa_pullup_o, // port a pull-up enable
  input wire logic [7:0] pb_pin_i, // port b pin levels
  output logic [7:0] pb_out_o, // port b drive value
  output logic [7:0] pb_oe_o, // port b output enable
  output logic [7:0] pb_pullup_o, // port b pull-up enable
  input wire logic spi_enable_i, // spi enabled
  input wire logic spi_master_i, // spi is master
  input wire logic usi_three_wire_i, // serial unit in three-wire mode
  input wire logic usi_data_out_i, // serial unit data output
  input wire logic uart_tx_enable_i, // uart transmitter enabled
  input wire logic uart_rx_enable_i, // uart receiver enabled
  input wire logic lin_enable_i, // lin controller enabled
  input wire logic lin_transmit_pin_i, // uart or lin transmit data
  input wire logic timer0_compare_a_en_i, // timer0 compare a connected
  input wire logic timer0_compare_a_i, // timer0 compare a level
  input wire logic timer1_compare_a_x_en_i, // timer1 compare a-x connected
  input wire logic timer1_compare_a_x_i, // timer1 compare a-x level
  input wire logic debug_drive_low_i, // debug link pulls reset pin low
  input wire logic divided_clock_i, // divided system clock
  input wire logic reset_pin_disable_fuse_i, // fuse programmed when high
  input wire logic one_wire_debug_fuse_i, // fuse programmed when high
  input wire logic lock_bits_programmed_i, // lock bits programmed
  input wire logic clock_output_fuse_i, // fuse programmed when high
  input wire logic clock_pin_used_i // crystal or external clock in use
);

  typedef struct packed {
    logic [7:0] port_control;
    logic [7:0] mcu_control;
    logic [7:0] dir_a;
    logic [7:0] outb_a;
    logic [7:0] dir_b;
    logic [7:0] outb_b;
    logic [7:0] hold_a;
    logic [7:0] hold_b;
    logic [15:0] pin_s1;
    logic [15:0] pin_s2;
    logic [ppc_pkg::FUSE_W-1:0] fuse_s1;
    logic [ppc_pkg::FUSE_W-1:0] fuse_s2;
    logic ack;
    logic [7:0] rdat;
    logic [7:0] oe_a;
    logic [7:0] do_a;
    logic [7:0] pu_a;
    logic [7:0] oe_b;
    logic [7:0] do_b;
    logic [7:0] pu_b;
  } ppc_state_s;

  ppc_state_s st_r;
  ppc_state_s st_nxt;

  // register select from the word index of the byte address
  function automatic logic hit(input logic [7:0] adr, input logic [5:0] idx);
    hit = (adr[7:2] == idx);
  endfunction

  logic req;
  logic pu_off_a;
  logic pu_off_b;
  logic rst_pin_mode;
  logic debug_mode;
  logic clk_out_on;
  logic clkpin;
  logic [7:0] de_a;
  logic [7:0] de_b;
  logic [7:0] in_a;
  logic [7:0] in_b;
  logic [7:0] rd_dir_b;
  logic [7:0] rd_out_b;
  logic [7:0] rd_in_b;
  logic [7:0] wd;
  logic [15:0] keep_s1;
  logic [15:0] keep_s2;
  logic [ppc_pkg::FUSE_W-1:0] keep_f1;
  logic [ppc_pkg::FUSE_W-1:0] keep_f2;

  // next state: sync, bus, pin muxing, freeze and reset
  always_comb
  begin
    st_nxt = st_r;
    wd = wb_dat_i[7:0];
    // two-stage synchronisers for pins and fuses
    st_nxt.pin_s1 = {pb_pin_i, pa_pin_i};
    st_nxt.pin_s2 = st_r.pin_s1;
    st_nxt.fuse_s1 = {clock_pin_used_i, clock_output_fuse_i,
                      lock_bits_programmed_i, one_wire_debug_fuse_i,
                      reset_pin_disable_fuse_i};
    st_nxt.fuse_s2 = st_r.fuse_s1;
    in_a = st_r.pin_s2[7:0];
    in_b = st_r.pin_s2[15:8];
    debug_mode = st_r.fuse_s2[ppc_pkg::FUSE_DEBUG]
               & ~st_r.fuse_s2[ppc_pkg::FUSE_LOCK];
    rst_pin_mode = ~st_r.fuse_s2[ppc_pkg::FUSE_RST_DIS];
    clk_out_on = st_r.fuse_s2[ppc_pkg::FUSE_CLK_OUT];
    clkpin = st_r.fuse_s2[ppc_pkg::FUSE_CLKPIN];
    // R1 R2: global OR port-wise pull-up off
    pu_off_a = st_r.mcu_control[ppc_pkg::GLOBAL_PULLUP_OFF]
             | st_r.port_control[ppc_pkg::PORT_A_PULLUP_OFF];
    pu_off_b = st_r.mcu_control[ppc_pkg::GLOBAL_PULLUP_OFF]
             | st_r.port_control[ppc_pkg::PORT_B_PULLUP_OFF];
    // R11 R15: non-I/O pins read zero
    rd_dir_b = st_r.dir_b;
    rd_out_b = st_r.outb_b;
    rd_in_b = in_b;
    if (rst_pin_mode)
    begin
      rd_dir_b[ppc_pkg::PIN_RESET] = 1'b0;
      rd_out_b[ppc_pkg::PIN_RESET] = 1'b0;
      rd_in_b[ppc_pkg::PIN_RESET] = 1'b0;
    end
    if (clkpin)
    begin
      rd_dir_b[ppc_pkg::PIN_CLOCK_IN] = 1'b0;
      rd_out_b[ppc_pkg::PIN_CLOCK_IN] = 1'b0;
      rd_in_b[ppc_pkg::PIN_CLOCK_IN] = 1'b0;
    end
    // wishbone slave: one ack per request, then drop for a cycle
    req = wb_cyc_i & wb_stb_i & ~st_r.ack;
    st_nxt.ack = req;
    st_nxt.rdat = 8'h00;
    st_nxt.hold_a = 8'h00;
    st_nxt.hold_b = 8'h00;
    if (req)
    begin
      if (hit(wb_adr_i, ppc_pkg::IDX_PA_IN)) st_nxt.rdat = in_a;
      if (hit(wb_adr_i, ppc_pkg::IDX_PA_DIR)) st_nxt.rdat = st_r.dir_a;
      if (hit(wb_adr_i, ppc_pkg::IDX_PA_OUT)) st_nxt.rdat = st_r.outb_a;
      if (hit(wb_adr_i, ppc_pkg::IDX_PB_IN)) st_nxt.rdat = rd_in_b;
      if (hit(wb_adr_i, ppc_pkg::IDX_PB_DIR)) st_nxt.rdat = rd_dir_b;
      if (hit(wb_adr_i, ppc_pkg::IDX_PB_OUT)) st_nxt.rdat = rd_out_b;
      if (hit(wb_adr_i, ppc_pkg::IDX_PORT_CONTROL))
        st_nxt.rdat = st_r.port_control;
      if (hit(wb_adr_i, ppc_pkg::IDX_MCU_CONTROL))
        st_nxt.rdat = st_r.mcu_control;
      if (wb_we_i && wb_sel_i[0])
      begin
        st_nxt.rdat = 8'h00;
        if (hit(wb_adr_i, ppc_pkg::IDX_PA_DIR))
        begin
          st_nxt.dir_a = wd;
          // R3: newly made outputs wait one tri-state cycle
          if (st_r.port_control[ppc_pkg::PORT_A_MAKE_DELAY])
            st_nxt.hold_a = wd & ~st_r.dir_a;
        end
        if (hit(wb_adr_i, ppc_pkg::IDX_PB_DIR))
        begin
          st_nxt.dir_b = wd;
          // R3: same break-before-make for port b
          if (st_r.port_control[ppc_pkg::PORT_B_MAKE_DELAY])
            st_nxt.hold_b = wd & ~st_r.dir_b;
        end
        if (hit(wb_adr_i, ppc_pkg::IDX_PA_OUT)) st_nxt.outb_a = wd;
        if (hit(wb_adr_i, ppc_pkg::IDX_PB_OUT)) st_nxt.outb_b = wd;
        // R16: reserved bits stay zero
        if (hit(wb_adr_i, ppc_pkg::IDX_PORT_CONTROL))
          st_nxt.port_control = wd & ppc_pkg::PORT_CONTROL_MASK;
        if (hit(wb_adr_i, ppc_pkg::IDX_MCU_CONTROL))
          st_nxt.mcu_control = wd & ppc_pkg::MCU_CONTROL_MASK;
      end
    end
    // effective directions and drive values
    de_a = st_r.dir_a;
    de_b = st_r.dir_b;
    st_nxt.do_a = st_r.outb_a;
    st_nxt.do_b = st_r.outb_b;
    // R4: spi slave forces mosi to input
    if (spi_enable_i && !spi_master_i) de_a[ppc_pkg::PIN_MOSI] = 1'b0;
    // R6: spi master forces miso to input
    if (spi_enable_i && spi_master_i) de_a[ppc_pkg::PIN_MISO] = 1'b0;
    // R13: timer output reaches the pin only through its direction bit
    if (timer0_compare_a_en_i)
      st_nxt.do_a[ppc_pkg::PIN_MISO] = timer0_compare_a_i;
    if (timer1_compare_a_x_en_i)
      st_nxt.do_b[ppc_pkg::PIN_T1_CMP] = timer1_compare_a_x_i;
    // R7: three-wire data replaces the output bit
    if (usi_three_wire_i) st_nxt.do_a[ppc_pkg::PIN_MISO] = usi_data_out_i;
    // R8: transmitter makes the transmit pin an output
    if (uart_tx_enable_i || lin_enable_i)
    begin
      de_a[ppc_pkg::PIN_TX] = 1'b1;
      st_nxt.do_a[ppc_pkg::PIN_TX] = lin_transmit_pin_i;
    end
    // R9: receiver makes the receive pin an input
    if (uart_rx_enable_i || lin_enable_i) de_a[ppc_pkg::PIN_RX] = 1'b0;
    // R5 R7 R10: input pins take pull-up from their output bit
    st_nxt.pu_a = ~de_a & st_r.outb_a & {8{~pu_off_a}};
    st_nxt.pu_b = ~de_b & st_r.outb_b & {8{~pu_off_b}};
    st_nxt.oe_a = de_a & ~st_r.hold_a;
    st_nxt.oe_b = de_b & ~st_r.hold_b;
    // R11 R12: reset pin as reset input or open-drain debug line
    if (debug_mode)
    begin
      st_nxt.oe_b[ppc_pkg::PIN_RESET] = debug_drive_low_i;
      st_nxt.do_b[ppc_pkg::PIN_RESET] = 1'b0;
      st_nxt.pu_b[ppc_pkg::PIN_RESET] = 1'b1;
    end
    else if (rst_pin_mode)
    begin
      st_nxt.oe_b[ppc_pkg::PIN_RESET] = 1'b0;
      st_nxt.do_b[ppc_pkg::PIN_RESET] = 1'b0;
      st_nxt.pu_b[ppc_pkg::PIN_RESET] = 1'b0;
    end
    // R15: clock input pin released from I/O
    if (clkpin)
    begin
      st_nxt.oe_b[ppc_pkg::PIN_CLOCK_IN] = 1'b0;
      st_nxt.do_b[ppc_pkg::PIN_CLOCK_IN] = 1'b0;
      st_nxt.pu_b[ppc_pkg::PIN_CLOCK_IN] = 1'b0;
    end
    // R14: divided clock overrides the pin bits
    if (clk_out_on)
    begin
      st_nxt.oe_b[ppc_pkg::PIN_CLOCK_OUT] = 1'b1;
      st_nxt.do_b[ppc_pkg::PIN_CLOCK_OUT] = divided_clock_i;
      st_nxt.pu_b[ppc_pkg::PIN_CLOCK_OUT] = 1'b0;
    end
    // freeze everything while the enable is low
    if (!ce_i) st_nxt = st_r;
    keep_s1 = st_nxt.pin_s1;
    keep_s2 = st_nxt.pin_s2;
    keep_f1 = st_nxt.fuse_s1;
    keep_f2 = st_nxt.fuse_s2;
    // reset clears state but keeps synchronisers running
    if (reset_i)
    begin
      st_nxt = '0;
      st_nxt.port_control = ppc_pkg::PORT_CONTROL_RST;
      st_nxt.mcu_control = ppc_pkg::MCU_CONTROL_RST;
      st_nxt.dir_a = ppc_pkg::PORT_DIR_RST;
      st_nxt.dir_b = ppc_pkg::PORT_DIR_RST;
      st_nxt.outb_a = ppc_pkg::PORT_OUT_RST;
      st_nxt.outb_b = ppc_pkg::PORT_OUT_RST;
      st_nxt.pin_s1 = keep_s1;
      st_nxt.pin_s2 = keep_s2;
      st_nxt.fuse_s1 = keep_f1;
      st_nxt.fuse_s2 = keep_f2;
      // R14: clock output also during reset
      st_nxt.oe_b[ppc_pkg::PIN_CLOCK_OUT] = clk_out_on;
      st_nxt.do_b[ppc_pkg::PIN_CLOCK_OUT] = clk_out_on & divided_clock_i;
    end
  end

  // single state register
  always_ff @(posedge mclk_i)
  begin
    st_r <= st_nxt;
  end

  // outputs straight from the state register
  assign wb_ack_o = st_r.ack;
  assign wb_dat_o = {24'h000000, st_r.rdat};
  assign pa_out_o = st_r.do_a;
  assign pa_oe_o = st_r.oe_a;
  assign pa_pullup_o = st_r.pu_a;
  assign pb_out_o = st_r.do_b;
  assign pb_oe_o = st_r.oe_b;
  assign pb_pullup_o = st_r.pu_b;

  // global pull-up off leaves only the debug pull-up
  global_pu_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R1
    ce_i && st_r.mcu_control[ppc_pkg::GLOBAL_PULLUP_OFF]
    |=> pa_pullup_o == 8'h00 && pb_pullup_o[6:0] == 7'h00)
    else $error("pull-up on with global off");
  port_pu_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R2
    ce_i && st_r.port_control[ppc_pkg::PORT_A_PULLUP_OFF]
    |=> pa_pullup_o == 8'h00)
    else $error("port a pull-up on with port off");
  make_delay_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R3
    ce_i && st_r.hold_a[3] ##1 ce_i
    |-> !pa_oe_o[3] ##1 pa_oe_o[3] == $past(st_r.dir_a[3]))
    else $error("break-before-make cycle wrong");
  mosi_in_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R4
    ce_i && spi_enable_i && !spi_master_i |=> !pa_oe_o[ppc_pkg::PIN_MOSI])
    else $error("mosi driven as slave");
  miso_in_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R6
    ce_i && spi_enable_i && spi_master_i |=> !pa_oe_o[ppc_pkg::PIN_MISO])
    else $error("miso driven as master");
  usi_data_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R7
    !reset_i && ce_i && usi_three_wire_i
    |=> pa_out_o[ppc_pkg::PIN_MISO] == $past(usi_data_out_i))
    else $error("three-wire data not on pin");
  tx_out_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R8
    !reset_i && ce_i && (uart_tx_enable_i || lin_enable_i)
    |=> pa_oe_o[ppc_pkg::PIN_TX])
    else $error("transmit pin not output");
  rx_pull_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R10
    !reset_i && ce_i && (uart_rx_enable_i || lin_enable_i) && !pu_off_a
    |=> !pa_oe_o[ppc_pkg::PIN_RX]
        && pa_pullup_o[ppc_pkg::PIN_RX] == $past(st_r.outb_a[ppc_pkg::PIN_RX]))
    else $error("receive pin pull-up wrong");
  debug_pin_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R12
    !reset_i && ce_i && debug_mode |=> pb_pullup_o[ppc_pkg::PIN_RESET]
    && !pb_out_o[ppc_pkg::PIN_RESET])
    else $error("debug pin not open-drain");
  clk_out_a: assert property (@(posedge mclk_i) // R14
    (ce_i || reset_i) && clk_out_on
    |=> pb_oe_o[ppc_pkg::PIN_CLOCK_OUT]
        && pb_out_o[ppc_pkg::PIN_CLOCK_OUT] == $past(divided_clock_i))
    else $error("divided clock not driven");

endmodule

// >>> testbench/ppc_board_model.sv
`timescale 1ns/1ps
module ppc_board_model (
  input wire logic mclk_i, // bench clock
  input wire logic [7:0] out_i, // drive value from the port
  input wire logic [7:0] oe_i, // port drives when high
  input wire logic [7:0] pullup_i, // pull-up switched on
  output logic [7:0] pin_o // level seen on the board
);
  // a floating line keeps no stale level, it wanders every cycle
  logic [7:0] idle_r = 8'h5A;
  always_ff @(posedge mclk_i)
  begin
    idle_r <= ~idle_r;
  end
  // driver first, then pull-up, else the wandering level
  assign pin_o = (oe_i & out_i) | (~oe_i & pullup_i)
    | (~oe_i & ~pullup_i & idle_r);
endmodule

// >>> testbench/tb_port_pin_control_override.sv
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      mismatches++; \
      $display("[ERR] %0t got %h expected %h", $time, g, e); \
    end \
  end
module tb_port_pin_control_override;
  logic mclk_i = 1'h0, reset_i = 1'h1;
  logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [3:0] wb_sel_i = 4'h0, sel_q = 4'hF;
  logic ce = 1'h1;
  logic [7:0] pa_pin, pa_out_o, pa_oe_o, pa_pullup_o;
  logic [7:0] pb_pin, pb_out_o, pb_oe_o, pb_pullup_o;
  logic spi_en = 1'h0, spi_mst = 1'h0, usi_3w = 1'h0, usi_do = 1'h0;
  logic tx_en = 1'h0, rx_en = 1'h0, lin_en = 1'h0, lin_tx = 1'h0;
  logic t0_en = 1'h0, t0_v = 1'h0, t1_en = 1'h0, t1_v = 1'h0;
  logic dbg_low = 1'h0, div_clk = 1'h0, f_rst = 1'h0, f_dbg = 1'h0;
  logic f_lock = 1'h0, f_ck = 1'h0, f_pin = 1'h0;
  int mismatches = 0, total_checks = 0;
  // 250 MHz clock and a divided clock toggling every rising edge
  always #2 mclk_i = ~mclk_i;
  always @(posedge mclk_i) div_clk <= ~div_clk;
  ppc_top dut (
    .mclk_i(mclk_i), .reset_i(reset_i), .ce_i(ce),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pa_pin_i(pa_pin), .pa_out_o(pa_out_o), .pa_oe_o(pa_oe_o),
    .pa_pullup_o(pa_pullup_o), .pb_pin_i(pb_pin), .pb_out_o(pb_out_o),
    .pb_oe_o(pb_oe_o), .pb_pullup_o(pb_pullup_o),
    .spi_enable_i(spi_en), .spi_master_i(spi_mst),
    .usi_three_wire_i(usi_3w), .usi_data_out_i(usi_do),
    .uart_tx_enable_i(tx_en), .uart_rx_enable_i(rx_en),
    .lin_enable_i(lin_en), .lin_transmit_pin_i(lin_tx),
    .timer0_compare_a_en_i(t0_en), .timer0_compare_a_i(t0_v),
    .timer1_compare_a_x_en_i(t1_en), .timer1_compare_a_x_i(t1_v),
    .debug_drive_low_i(dbg_low), .divided_clock_i(div_clk),
    .reset_pin_disable_fuse_i(f_rst), .one_wire_debug_fuse_i(f_dbg),
    .lock_bits_programmed_i(f_lock), .clock_output_fuse_i(f_ck),
    .clock_pin_used_i(f_pin)
  );
  // board circuitry on both ports
  ppc_board_model brd_a (.mclk_i(mclk_i), .out_i(pa_out_o),
    .oe_i(pa_oe_o), .pullup_i(pa_pullup_o), .pin_o(pa_pin));
  ppc_board_model brd_b (.mclk_i(mclk_i), .out_i(pb_out_o),
    .oe_i(pb_oe_o), .pullup_i(pb_pullup_o), .pin_o(pb_pin));
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // one classic cycle; returns at the edge that sampled ack
  task automatic xfer(input logic we, input logic [5:0] idx,
    input logic [7:0] wd);
    int n;
    @(posedge mclk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'h0};
    wb_sel_i <= sel_q;
    wb_dat_i <= {24'h0, wd};
    n = 0;
    do
    begin
      @(posedge mclk_i);
      n++;
    end
    while (wb_ack_o !== 1'h1 && n < 20);
    if (n >= 20)
    begin
      mismatches++;
      $display("[ERR] %0t bus answer timed out", $time);
      conclude();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  task automatic rchk(input logic [5:0] idx, input logic [7:0] e);
    xfer(1'h0, idx, 8'h00);
    `CHK(rd, e)
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  initial
  begin
    repeat (3) @(posedge mclk_i);
    reset_i <= 1'h0;
    // reset values, reserved bits, unmapped place
    rchk(ppc_pkg::IDX_PORT_CONTROL, 8'h00);
    rchk(ppc_pkg::IDX_MCU_CONTROL, 8'h00);
    xfer(1'h1, ppc_pkg::IDX_PORT_CONTROL, 8'hFF);
    rchk(ppc_pkg::IDX_PORT_CONTROL, 8'h33);
    xfer(1'h1, ppc_pkg::IDX_MCU_CONTROL, 8'hFF);
    rchk(ppc_pkg::IDX_MCU_CONTROL, 8'h70);
    xfer(1'h1, 6'h3F, 8'hFF);
    rchk(6'h3F, 8'h00);
    // a write with lane 0 off is acked but ignored
    sel_q = 4'hE;
    xfer(1'h1, ppc_pkg::IDX_PORT_CONTROL, 8'h00);
    sel_q = 4'hF;
    rchk(ppc_pkg::IDX_PORT_CONTROL, 8'h33);
    // global and port pull-up gating
    xfer(1'h1, ppc_pkg::IDX_PORT_CONTROL, 8'h00);
    xfer(1'h1, ppc_pkg::IDX_MCU_CONTROL, 8'h00);
    xfer(1'h1, ppc_pkg::IDX_PA_OUT, 8'hFF);
    xfer(1'h1, ppc_pkg::IDX_PB_OUT, 8'hFF);
    tick(3);
    `CHK(pa_pullup_o, 8'hFF)
    `CHK(pb_pullup_o, 8'h7F)
    rchk(ppc_pkg::IDX_PA_IN, 8'hFF);
    rchk(ppc_pkg::IDX_PB_IN, 8'h7F);
    xfer(1'h1, ppc_pkg::IDX_PORT_CONTROL, 8'h01);
    tick(1);
    `CHK(pa_pullup_o, 8'h00)
    `CHK(pb_pullup_o, 8'h7F)
    xfer(1'h1, ppc_pkg::IDX_PORT_CONTROL, 8'h00);
    xfer(1'h1, ppc_pkg::IDX_MCU_CONTROL, 8'h10);
    tick(1);
    `CHK(pa_pullup_o | pb_pullup_o, 8'h00)
    xfer(1'h1, ppc_pkg::IDX_MCU_CONTROL, 8'h00);
    // tri-state cycle only on the delayed port
    xfer(1'h1, ppc_pkg::IDX_PORT_CONTROL, 8'h10);
    xfer(1'h1, ppc_pkg::IDX_PA_DIR, 8'h08);
    #1;
    `CHK(pa_oe_o[3], 1'h0)
    tick(1);
    `CHK(pa_oe_o[3], 1'h1)
    xfer(1'h1, ppc_pkg::IDX_PORT_CONTROL, 8'h20);
    xfer(1'h1, ppc_pkg::IDX_PA_DIR, 8'hFF);
    #1;
    `CHK(pa_oe_o[4], 1'h1)
    // serial peripheral slave then master
    @(posedge mclk_i);
    spi_en <= 1'h1;
    tick(2);
    `CHK({pa_oe_o[4], pa_pullup_o[4], pa_oe_o[2]}, 3'h3)
    @(posedge mclk_i);
    spi_mst <= 1'h1;
    tick(2);
    `CHK({pa_oe_o[4], pa_oe_o[2], pa_pullup_o[2]}, 3'h5)
    // three-wire data overrides the output bit
    @(posedge mclk_i);
    spi_en <= 1'h0;
    usi_3w <= 1'h1;
    tick(2);
    `CHK({pa_out_o[2], pa_oe_o[2]}, 2'h1)
    xfer(1'h1, ppc_pkg::IDX_PA_DIR, 8'hFB);
    tick(1);
    `CHK({pa_oe_o[2], pa_pullup_o[2]}, 2'h1)
    // timer output needs its direction bit set first
    @(posedge mclk_i);
    usi_3w <= 1'h0;
    t0_en <= 1'h1;
    xfer(1'h1, ppc_pkg::IDX_PA_DIR, 8'hFD);
    tick(1);
    `CHK({pa_out_o[2], pa_oe_o[2]}, 2'h1)
    // enable low freezes the pins, then they catch up
    @(posedge mclk_i);
    ce <= 1'h0;
    t0_v <= 1'h1;
    tick(2);
    `CHK(pa_out_o[2], 1'h0)
    @(posedge mclk_i);
    ce <= 1'h1;
    tick(2);
    `CHK(pa_out_o[2], 1'h1)
    // transmitter, receiver and link enables
    for (int k = 0; k < 3; k++)
    begin
      @(posedge mclk_i);
      tx_en <= (k == 0);
      rx_en <= (k == 1);
      lin_en <= (k == 2);
      lin_tx <= (k == 2);
      tick(2);
      `CHK(pa_out_o[1], k != 0)
      `CHK(pa_oe_o[1], k != 1)
      `CHK(pa_oe_o[0], k == 0)
      `CHK(pa_pullup_o[0], k != 0)
    end
    // reset pin, debug pin, clock pins on port b
    xfer(1'h1, ppc_pkg::IDX_PB_DIR, 8'hFF);
    rchk(ppc_pkg::IDX_PB_DIR, 8'h7F);
    rchk(ppc_pkg::IDX_PB_OUT, 8'h7F);
    `CHK(pb_oe_o[7], 1'h0)
    @(posedge mclk_i);
    t1_en <= 1'h1;
    f_rst <= 1'h1;
    tick(4);
    `CHK(pb_out_o[6], 1'h0)
    rchk(ppc_pkg::IDX_PB_DIR, 8'hFF);
    `CHK(pb_oe_o[7], 1'h1)
    @(posedge mclk_i);
    f_rst <= 1'h0;
    f_dbg <= 1'h1;
    dbg_low <= 1'h1;
    tick(4);
    `CHK({pb_pullup_o[7], pb_oe_o[7], pb_out_o[7]}, 3'h6)
    @(posedge mclk_i);
    dbg_low <= 1'h0;
    f_lock <= 1'h1;
    f_pin <= 1'h1;
    tick(4);
    `CHK({pb_pullup_o[7], pb_oe_o[7], pb_oe_o[4]}, 3'h0)
    rchk(ppc_pkg::IDX_PB_DIR, 8'h6F);
    rchk(ppc_pkg::IDX_PB_IN, 8'h2F);
    xfer(1'h1, ppc_pkg::IDX_PB_DIR, 8'h00);
    @(posedge mclk_i);
    f_ck <= 1'h1;
    tick(4);
    `CHK({pb_oe_o[5], pb_out_o[5]}, {1'h1, ~div_clk})
    @(posedge mclk_i);
    reset_i <= 1'h1;
    tick(2);
    `CHK({pb_oe_o[5], pb_out_o[5]}, {1'h1, ~div_clk})
    `CHK(pa_oe_o, 8'h00)
    @(posedge mclk_i);
    reset_i <= 1'h0;
    rchk(ppc_pkg::IDX_PA_DIR, 8'h00);
    conclude();
  end
endmodule
